/* File: bench/drt_assertions.sv */
// Purpose: Port checks for the reload/indirect DMA channel
// Assumes: One clock, reset active low
// Notes: Bound to the channel top
`timescale 1ns/10ps
module drt_chk (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [3:0] PSTRB,
  input wire logic PSLVERR,
  input wire logic REQ_CLR,
  input wire logic BUS_REQ,
  input wire drt_pkg::drt_mem_s MEM_OUT,
  input wire logic MEM_WAIT,
  input wire logic IRQ
);
  import drt_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic ign;
  // Beat that ends regardless of wait
  assign ign = MEM_OUT.we && MEM_OUT.size == SZ_16B && MEM_OUT.addr < EXT_SPACE_TOP;
  // Bus and memory relations
  AST_MEM_OWN: assert property (MEM_OUT.req |-> BUS_REQ)
    else $error("memory cycle without bus request");
  AST_MEM_HOLD: assert property (MEM_OUT.req && MEM_WAIT && !ign |=> $stable(MEM_OUT))
    else $error("stalled cycle changed");
  AST_WAIT_IGN: assert property (MEM_OUT.req && MEM_WAIT && ign |=>
    !MEM_OUT.req || MEM_OUT.addr != $past(MEM_OUT.addr))
    else $error("wait not ignored");
  AST_CLR_PULSE: assert property (REQ_CLR |=> !REQ_CLR)
    else $error("flag clear longer than a cycle");
  AST_CLR_RELEASE: assert property (REQ_CLR |-> !BUS_REQ && !MEM_OUT.req)
    else $error("flag clear while bus held");
  AST_IRQ_CAUSE: assert property ($rose(IRQ) |-> REQ_CLR)
    else $error("interrupt without count end");
  AST_IRQ_CLEAR: assert property ($fell(IRQ) |-> $past(PENABLE) && $past(PWRITE))
    else $error("interrupt dropped without write");
  // Register port refusals
  AST_ERR_MAP: assert property (PSEL && PENABLE && PADDR > OFS_OPER |-> PSLVERR)
    else $error("unmapped access accepted");
  AST_ERR_SIZE: assert property (PSEL && PENABLE && PWRITE && PADDR == OFS_OPER
    && PSTRB[3:2] != 2'h0 |-> PSLVERR)
    else $error("wide operation write accepted");
endmodule : drt_chk
bind drt_dma_top drt_chk u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PSTRB(PSTRB), .PSLVERR(PSLVERR),
  .REQ_CLR(REQ_CLR), .BUS_REQ(BUS_REQ), .MEM_OUT(MEM_OUT), .MEM_WAIT(MEM_WAIT), .IRQ(IRQ));

/* File: bench/drt_dma_top_bench.sv */
// Purpose: Register-level tests of the DMA channel
// Assumes: Memory partner returns address xor key
// Notes: Transfers checked from the partner's logs
`timescale 1ns/10ps
module drt_dma_top_bench;
  import drt_pkg::*;
  localparam logic [31:0] KEY = 32'h0a0b_0c0d;
  logic REF_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, REQ_IN, REQ_CLR;
  logic BUS_REQ, BUS_GRANT, NMI, MEM_WAIT, IRQ, SLOW, err, breq_q;
  logic [7:0] PADDR;
  logic [3:0] PSTRB;
  logic [31:0] PWDATA, PRDATA, MEM_RDATA, rd;
  drt_mem_s MEM_OUT;
  int bad_count, checked, n_clr, n_rel, cyc;
  drt_dma_top u_dut (.*);
  drt_mem_model u_mem (.*);
  task automatic finish_test;
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1)
      @(posedge REF_CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask : apb
  // Program a channel and wait for its writes and release
  task automatic run(input logic [31:0] s, dd, c, input int n);
    u_mem.wq_a.delete();
    u_mem.wq_d.delete();
    u_mem.wq_t.delete();
    u_mem.rq_a.delete();
    u_mem.rq_s.delete();
    n_clr = 0;
    n_rel = 0;
    apb(1'b1, OFS_SRC, s, 4'hf);
    apb(1'b1, OFS_DST, dd, 4'hf);
    apb(1'b1, OFS_CNT, 32'(n), 4'hf);
    apb(1'b1, OFS_CTRL, c, 4'hf);
    apb(1'b1, OFS_OPER, 32'h1, 4'h3);
    while (u_mem.wq_a.size() < n)
      @(posedge REF_CLK);
    @(posedge REF_CLK);
    while (BUS_REQ !== 1'b0)
      @(posedge REF_CLK);
  endtask : run
  // Stop the channel and zero its count before reuse
  task automatic stop;
    apb(1'b1, OFS_OPER, 32'h0, 4'h3);
    // Let an accepted transfer finish before touching the channel
    while (BUS_REQ !== 1'b0)
      @(posedge REF_CLK);
    apb(1'b1, OFS_CTRL, 32'h0, 4'hf);
    apb(1'b1, OFS_CNT, 32'h0, 4'hf);
  endtask : stop
  initial
  begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end
  // Flag-clear and bus-release counters, timeout
  always @(negedge REF_CLK)
  begin
    breq_q <= BUS_REQ;
    cyc++;
    if (REQ_CLR === 1'b1)
      n_clr++;
    if (breq_q === 1'b1 && BUS_REQ === 1'b0)
      n_rel++;
    if (cyc == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end
  initial
  begin
    {RST_N, PSEL, PENABLE, PWRITE, REQ_IN, NMI, SLOW} = 7'h0;
    {PADDR, PSTRB, PWDATA} = 44'h0;
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    apb(1'b0, 8'h20, 32'h0, 4'hf);
    chk("unmapped error", err, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, OFS_OPER, 32'h1, 4'hf);
    chk("oper long write error", err, 32'h1);
    apb(1'b1, OFS_SRC, 32'h55, 4'h1);
    chk("source byte write error", err, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h200, 4'h2);
    apb(1'b0, OFS_CTRL, 32'h0, 4'hf);
    chk("control byte write", rd, 32'h200);
    apb(1'b0, OFS_OPER, 32'h0, 4'h3);
    chk("oper unchanged", rd, 32'h0);
    apb(1'b0, OFS_SRC, 32'h0, 4'hf);
    chk("source unchanged", rd, 32'h0);
    // Flag set by the nmi input while idle
    NMI <= 1'b1;
    @(posedge REF_CLK);
    NMI <= 1'b0;
    apb(1'b0, OFS_OPER, 32'h0, 4'h3);
    chk("nmi flag", rd, 32'h2);
    stop();
    // Burst longword transfers, reload on then off, partner slow then prompt
    for (int r = 1; r >= 0; r--)
    begin
      SLOW <= r[0];
      run(32'h0400_0080, 32'h0040_0000, r ? 32'h621d : 32'h620d, 8);
      for (int i = 0; i < 8; i++)
      begin
        chk("dest addr", u_mem.wq_a[i], 32'h0040_0000 - 4 * i);
        chk("write data", u_mem.wq_d[i], (32'h0400_0080 + 4 * (r ? i % 4 : i)) ^ KEY);
      end
      apb(1'b0, OFS_SRC, 32'h0, 4'hf);
      chk("final source", rd, r ? 32'h0400_0080 : 32'h0400_00a0);
      apb(1'b0, OFS_DST, 32'h0, 4'hf);
      chk("final dest", rd, 32'h003f_ffe0);
      apb(1'b0, OFS_CNT, 32'h0, 4'hf);
      chk("final count", rd, 32'h0);
      chk("end interrupt", IRQ, 32'h1);
      chk("flag clears", n_clr, r ? 32'h2 : 32'h1);
      chk("bus releases", n_rel, r ? 32'h2 : 32'h1);
      stop();
    end
    // Indirect byte transfers; request line held high through setup
    REQ_IN <= 1'b1;
    run(32'h0040_0010, 32'h0400_0156, 32'h0001_4021, 2);
    for (int i = 0; i < 2; i++)
    begin
      chk("pointer addr", u_mem.rq_a[2 * i], 32'h0040_0010 + 4 * i);
      chk("pointer size", u_mem.rq_s[2 * i], 32'(SZ_LONG));
      chk("data addr", u_mem.rq_a[2 * i + 1], (32'h0040_0010 + 4 * i) ^ KEY);
      chk("data size", u_mem.rq_s[2 * i + 1], 32'(SZ_BYTE));
      chk("indirect write addr", u_mem.wq_a[i], 32'h0400_0156);
      chk("indirect write data", u_mem.wq_d[i], 32'h0040_0010 + 4 * i);
    end
    apb(1'b0, OFS_SRC, 32'h0, 4'hf);
    chk("indirect source", rd, 32'h0040_0018);
    chk("no interrupt", IRQ, 32'h0);
    chk("count end clear", n_clr, 32'h1);
    stop();
    REQ_IN <= 1'b0;
    // Sixteen-byte write to external space with a stalling partner
    SLOW <= 1'b1;
    run(32'h0400_0000, 32'h0040_0000, 32'h0000_5301, 4);
    for (int i = 0; i < 4; i++)
    begin
      chk("beat addr", u_mem.wq_a[i], 32'h0040_0000 + 4 * i);
      chk("beat data", u_mem.wq_d[i], (32'h0400_0000 + 4 * i) ^ KEY);
      chk("beat ack", u_mem.wq_t[i], 32'h0);
    end
    stop();
    // Single-address sixteen-byte write, acknowledged device supplies data
    run(32'h0, 32'h0040_0000, 32'h0000_1341, 1);
    for (int i = 0; i < 4; i++)
    begin
      chk("single addr", u_mem.wq_a[i], 32'h0040_0000 + 4 * i);
      chk("single data", u_mem.wq_d[i], 32'h0);
      chk("single ack", u_mem.wq_t[i], 32'h1);
    end
    stop();
    finish_test();
  end
endmodule : drt_dma_top_bench

/* File: bench/drt_mem_model.sv */
// Purpose: Memory and bus grant partner for the DMA channel
// Assumes: Read data is the address xor a fixed key
// Notes: Slow mode raises wait on every other clock while a memory cycle is active
`timescale 1ns/10ps
module drt_mem_model (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic SLOW,
  input wire drt_pkg::drt_mem_s MEM_OUT,
  input wire logic BUS_REQ,
  output logic BUS_GRANT,
  output logic [31:0] MEM_RDATA,
  output logic MEM_WAIT
);
  import drt_pkg::*;
  localparam logic [31:0] KEY = 32'h0a0b_0c0d;
  logic [31:0] last_q;
  logic ign;
  logic [31:0] wq_a[$];
  logic [31:0] wq_d[$];
  logic [31:0] wq_t[$];
  logic [31:0] rq_a[$];
  logic [31:0] rq_s[$];
  // Data only during a read, else a changing pattern
  assign MEM_RDATA = (MEM_OUT.req && !MEM_OUT.we) ? MEM_OUT.addr ^ KEY : ~last_q;
  assign ign = MEM_OUT.we && MEM_OUT.size == SZ_16B && MEM_OUT.addr < EXT_SPACE_TOP;
  // Grant a cycle after request; log finished cycles
  always @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
    begin
      BUS_GRANT <= 1'b0;
      MEM_WAIT <= 1'b0;
      last_q <= 32'h0;
    end
    else
    begin
      BUS_GRANT <= BUS_REQ;
      last_q <= MEM_RDATA;
      MEM_WAIT <= SLOW && MEM_OUT.req && !MEM_WAIT;
      if (MEM_OUT.req && (!MEM_WAIT || ign) && MEM_OUT.we)
      begin
        wq_a.push_back(MEM_OUT.addr);
        wq_d.push_back(MEM_OUT.wdata);
        wq_t.push_back(32'(MEM_OUT.tack));
      end
      if (MEM_OUT.req && !MEM_WAIT && !MEM_OUT.we)
      begin
        rq_a.push_back(MEM_OUT.addr);
        rq_s.push_back(32'(MEM_OUT.size));
      end
    end
endmodule : drt_mem_model

/* File: common/drt_pkg.sv */
// Purpose: Shared constants and types for the reload/indirect DMA channel
// Assumes: APB register port, 32-bit data, one channel, one clock
// Notes: Byte offsets are the APB byte addresses of aligned words
package drt_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_SRC = 8'h00;
  localparam logic [7:0] OFS_DST = 8'h04;
  localparam logic [7:0] OFS_CNT = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_OPER = 8'h10;

  // Channel control field positions
  localparam int CTL_DE = 0;
  localparam int CTL_TE = 1;
  localparam int CTL_IE = 2;
  localparam int CTL_BURST = 3;
  localparam int CTL_RELOAD = 4;
  localparam int CTL_INDIR = 5;
  localparam int CTL_SINGLE = 6;
  localparam int CTL_SIZE_LO = 8;
  localparam int CTL_DSTEP_LO = 12;
  localparam int CTL_SSTEP_LO = 14;
  localparam int CTL_RS_LO = 16;
  localparam logic [31:0] CTL_MASK = 32'h000f_f37f;

  // Operation register field positions
  localparam int OPR_DME = 0;
  localparam int OPR_NMI_SEEN_FLAG = 1;
  localparam logic [15:0] OPR_MASK = 16'h0003;

  // Reset values and sizes
  localparam int CNT_W = 24;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h00_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] OPER_RST = 16'h0000;

  // Group, beat and space constants
  localparam logic [1:0] GROUP_LAST = 2'h3;
  localparam logic [1:0] BEAT_LAST = 2'h3;
  localparam logic [31:0] EXT_SPACE_TOP = 32'h0400_0000;
  localparam logic [3:0] RS_AUTO = 4'h0;
  localparam logic [31:0] LONG_STEP = 32'h0000_0004;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_16B} drt_size_e;
  typedef enum logic [1:0] {ST_FIXED, ST_INC, ST_DEC, ST_RSVD} drt_step_e;
  typedef enum logic [2:0] {PH_IDLE, PH_GRANT, PH_PTR, PH_READ, PH_WRITE} drt_phase_e;

  // Command from the channel to the bus cycle unit
  typedef struct packed {
    logic start;
    logic we;
    logic tack;
    logic no_wait;
    drt_size_e size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } drt_cmd_s;

  // Memory bus outputs
  typedef struct packed {
    logic req;
    logic we;
    logic tack;
    drt_size_e size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } drt_mem_s;

endpackage : drt_pkg

/* File: hw/drt_dma_top.sv */
// Purpose: Single DMA channel with address reload and indirect source
// Assumes: APB slave with zero wait states; bus grant from the CPU side
// Notes: Request line is a level; request flag cleared by a pulse
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module drt_dma_top (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic REQ_IN,
  output logic REQ_CLR,
  output logic BUS_REQ,
  input wire logic BUS_GRANT,
  input wire logic NMI,
  output drt_pkg::drt_mem_s MEM_OUT,
  input wire logic [31:0] MEM_RDATA,
  input wire logic MEM_WAIT,
  output logic IRQ
);
  import drt_pkg::*;

  typedef struct packed {
    drt_phase_e phase;
    logic [31:0] source_address_reg;
    logic [31:0] sar_init;
    logic [31:0] dest_address_reg;
    logic [31:0] ptr;
    logic [CNT_W-1:0] cnt;
    logic [31:0] ctrl;
    logic [15:0] oper;
    logic [1:0] grp;
    logic [1:0] beat;
    logic [3:0][31:0] buff;
    logic bus_req;
    logic req_clr;
    logic [31:0] prdata;
    logic pslverr;
  } drt_state_s;

  drt_state_s st_ff;
  drt_state_s nxt_st;
  drt_cmd_s cmd;
  logic cyc_done;

  // Byte count of one transfer unit
  function automatic logic [31:0] size_bytes(input drt_size_e sz);
    case (sz)
      SZ_BYTE: size_bytes = 32'h0000_0001;
      SZ_WORD: size_bytes = 32'h0000_0002;
      SZ_LONG: size_bytes = 32'h0000_0004;
      default: size_bytes = 32'h0000_0010;
    endcase
  endfunction : size_bytes

  // Address stepping by mode
  function automatic logic [31:0] step_addr(input logic [31:0] a, input drt_step_e m,
                                            input logic [31:0] amt);
    case (m)
      ST_INC: step_addr = a + amt;
      ST_DEC: step_addr = a - amt;
      default: step_addr = a;
    endcase
  endfunction : step_addr

  // External space lies below the on-chip region
  function automatic logic is_ext(input logic [31:0] a);
    is_ext = (a < EXT_SPACE_TOP);
  endfunction : is_ext

  // Offset of a longword beat within a 16-byte unit
  function automatic logic [31:0] beat_ofs(input logic [1:0] b);
    beat_ofs = {28'h000_0000, b, 2'b00};
  endfunction : beat_ofs

  // Byte lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // Allowed write sizes per register
  function automatic logic strb_ok(input logic [7:0] ofs, input logic [3:0] strb);
    case (ofs)
      OFS_CTRL: strb_ok = 1'b1;
      OFS_OPER: strb_ok = (strb == 4'h1) || (strb == 4'h2) || (strb == 4'h3);
      OFS_SRC, OFS_DST, OFS_CNT:
        strb_ok = (strb == 4'h3) || (strb == 4'hc) || (strb == 4'hf);
      default: strb_ok = 1'b0;
    endcase
  endfunction : strb_ok

  // Opening bus cycle of one transfer
  function automatic drt_cmd_s first_cmd(input logic [31:0] c, input logic [31:0] s,
                                         input logic [31:0] d);
    drt_cmd_s r;
    r = '0;
    r.start = 1'b1;
    r.size = drt_size_e'(c[CTL_SIZE_LO +: 2]);
    if (c[CTL_SINGLE])
    begin
      r.we = 1'b1;
      r.tack = 1'b1;
      r.addr = d;
      r.no_wait = (r.size == SZ_16B) && is_ext(d);
    end
    else if (c[CTL_INDIR])
    begin
      r.size = SZ_LONG;
      r.addr = s;
    end
    else
    begin
      r.addr = s;
    end
    first_cmd = r;
  endfunction : first_cmd

  // Phase that follows the opening cycle
  function automatic drt_phase_e first_phase(input logic [31:0] c);
    if (c[CTL_SINGLE])
    begin
      first_phase = PH_WRITE;
    end
    else if (c[CTL_INDIR])
    begin
      first_phase = PH_PTR;
    end
    else
    begin
      first_phase = PH_READ;
    end
  endfunction : first_phase

  drt_mem_cycle u_cycle (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .cmd(cmd),
    .mem_wait(MEM_WAIT),
    .mem(MEM_OUT),
    .done(cyc_done)
  );

  // Register and handshake outputs
  assign PREADY = 1'b1;
  assign PRDATA = st_ff.prdata;
  assign PSLVERR = st_ff.pslverr;
  assign BUS_REQ = st_ff.bus_req;
  assign REQ_CLR = st_ff.req_clr;
  assign IRQ = st_ff.ctrl[CTL_TE] & st_ff.ctrl[CTL_IE];

  // Register access and transfer sequencing
  always_comb
  begin
    logic en;
    logic want;
    logic big;
    logic last;
    logic reload;
    drt_size_e sz;
    logic [31:0] nsar;
    logic [31:0] ndar;
    logic [31:0] base;
    logic [CNT_W-1:0] ncnt;
    logic [31:0] wmerged;
    en = 1'b0;
    want = 1'b0;
    big = 1'b0;
    last = 1'b0;
    reload = 1'b0;
    sz = SZ_BYTE;
    nsar = '0;
    ndar = '0;
    base = '0;
    ncnt = '0;
    wmerged = '0;
    nxt_st = st_ff;
    nxt_st.req_clr = 1'b0;
    cmd = '0;

    // Setup phase: capture read data and the access verdict
    if (PSEL && !PENABLE)
    begin
      nxt_st.pslverr = PWRITE && !strb_ok(PADDR, PSTRB);
      case (PADDR)
        OFS_SRC: nxt_st.prdata = st_ff.source_address_reg;
        OFS_DST: nxt_st.prdata = st_ff.dest_address_reg;
        OFS_CNT: nxt_st.prdata = {8'h00, st_ff.cnt};
        OFS_CTRL: nxt_st.prdata = st_ff.ctrl;
        OFS_OPER: nxt_st.prdata = {16'h0000, st_ff.oper};
        default:
        begin
          nxt_st.prdata = 32'h0000_0000;
          nxt_st.pslverr = 1'b1;
        end
      endcase
    end

    // Access phase: register writes, refused sizes leave no effect
    if (PSEL && PENABLE && PWRITE && !st_ff.pslverr)
    begin
      case (PADDR)
        OFS_SRC:
        begin
          nxt_st.source_address_reg = merge(st_ff.source_address_reg, PWDATA, PSTRB);
          nxt_st.sar_init = nxt_st.source_address_reg;
          nxt_st.grp = 2'h0;
        end
        OFS_DST: nxt_st.dest_address_reg = merge(st_ff.dest_address_reg, PWDATA, PSTRB);
        OFS_CNT:
        begin
          wmerged = merge({8'h00, st_ff.cnt}, PWDATA, PSTRB);
          nxt_st.cnt = wmerged[CNT_W-1:0];
        end
        OFS_CTRL:
        begin
          // Done flag can only be cleared by writing zero
          nxt_st.ctrl = merge(st_ff.ctrl, PWDATA, PSTRB) & CTL_MASK;
          nxt_st.ctrl[CTL_TE] = st_ff.ctrl[CTL_TE] & nxt_st.ctrl[CTL_TE];
        end
        OFS_OPER:
        begin
          wmerged = merge({16'h0000, st_ff.oper}, PWDATA, PSTRB);
          nxt_st.oper = wmerged[15:0] & OPR_MASK;
          nxt_st.oper[OPR_NMI_SEEN_FLAG] = st_ff.oper[OPR_NMI_SEEN_FLAG] & wmerged[OPR_NMI_SEEN_FLAG];
        end
        default: nxt_st.oper = st_ff.oper;
      endcase
    end

    // NMI sets its flag in any phase; set wins over clear
    if (NMI)
    begin
      nxt_st.oper[OPR_NMI_SEEN_FLAG] = 1'b1;
    end

    // Channel qualifiers from current state
    en = st_ff.oper[OPR_DME] & ~st_ff.oper[OPR_NMI_SEEN_FLAG] & st_ff.ctrl[CTL_DE]
         & ~st_ff.ctrl[CTL_TE];
    want = en & ((st_ff.ctrl[CTL_RS_LO +: 4] == RS_AUTO) | REQ_IN);
    sz = drt_size_e'(st_ff.ctrl[CTL_SIZE_LO +: 2]);
    big = (sz == SZ_16B);
    last = !big || (st_ff.beat == BEAT_LAST);
    reload = st_ff.ctrl[CTL_RELOAD];
    base = st_ff.ctrl[CTL_INDIR] ? st_ff.ptr : st_ff.source_address_reg;

    // Transfer sequencer
    case (st_ff.phase)
      PH_IDLE:
      begin
        if (want)
        begin
          nxt_st.bus_req = 1'b1;
          nxt_st.phase = PH_GRANT;
        end
      end
      PH_GRANT:
      begin
        if (!en)
        begin
          nxt_st.bus_req = 1'b0;
          nxt_st.phase = PH_IDLE;
        end
        else if (BUS_GRANT)
        begin
          cmd = first_cmd(st_ff.ctrl, st_ff.source_address_reg, st_ff.dest_address_reg);
          nxt_st.beat = 2'h0;
          nxt_st.phase = first_phase(st_ff.ctrl);
        end
      end
      PH_PTR:
      begin
        // Pointer fetched, read the data it names
        if (cyc_done)
        begin
          nxt_st.ptr = MEM_RDATA;
          cmd.start = 1'b1;
          cmd.size = sz;
          cmd.addr = MEM_RDATA;
          nxt_st.phase = PH_READ;
        end
      end
      PH_READ:
      begin
        if (cyc_done)
        begin
          nxt_st.buff[st_ff.beat] = MEM_RDATA;
          cmd.start = 1'b1;
          cmd.size = sz;
          if (!last)
          begin
            nxt_st.beat = st_ff.beat + 2'h1;
            cmd.addr = base + beat_ofs(nxt_st.beat);
          end
          else
          begin
            // Destination write as in plain dual-address transfer
            nxt_st.beat = 2'h0;
            nxt_st.phase = PH_WRITE;
            cmd.we = 1'b1;
            cmd.addr = st_ff.dest_address_reg;
            cmd.wdata = big ? st_ff.buff[0] : MEM_RDATA;
            cmd.no_wait = big && is_ext(st_ff.dest_address_reg);
          end
        end
      end
      PH_WRITE:
      begin
        if (cyc_done && !last)
        begin
          nxt_st.beat = st_ff.beat + 2'h1;
          cmd.start = 1'b1;
          cmd.we = 1'b1;
          cmd.tack = st_ff.ctrl[CTL_SINGLE];
          cmd.size = sz;
          cmd.addr = st_ff.dest_address_reg + beat_ofs(nxt_st.beat);
          cmd.wdata = st_ff.ctrl[CTL_SINGLE] ? 32'h0000_0000 : st_ff.buff[nxt_st.beat]; // Device data
          cmd.no_wait = is_ext(st_ff.dest_address_reg);
        end
        else if (cyc_done)
        begin
          // One transfer complete: count, step, decide what follows
          nxt_st.beat = 2'h0;
          ncnt = st_ff.cnt - 24'h00_0001;
          nxt_st.cnt = ncnt;
          nxt_st.grp = st_ff.grp + 2'h1;
          ndar = step_addr(st_ff.dest_address_reg, drt_step_e'(st_ff.ctrl[CTL_DSTEP_LO +: 2]),
                           size_bytes(sz));
          if (reload && (st_ff.grp == GROUP_LAST))
          begin
            nsar = st_ff.sar_init;
          end
          else
          begin
            nsar = step_addr(st_ff.source_address_reg, drt_step_e'(st_ff.ctrl[CTL_SSTEP_LO +: 2]),
                             st_ff.ctrl[CTL_INDIR] ? LONG_STEP : size_bytes(sz));
          end
          nxt_st.source_address_reg = nsar;
          nxt_st.dest_address_reg = ndar;
          if (ncnt == CNT_RST)
          begin
            nxt_st.ctrl[CTL_TE] = 1'b1;
            nxt_st.req_clr = 1'b1;
            nxt_st.bus_req = 1'b0;
            nxt_st.phase = PH_IDLE;
          end
          else if (reload && (st_ff.grp == GROUP_LAST))
          begin
            nxt_st.req_clr = 1'b1;
            nxt_st.bus_req = 1'b0;
            nxt_st.phase = PH_IDLE;
          end
          else if (st_ff.ctrl[CTL_BURST] && want)
          begin
            // Keep the bus and start the next transfer at once
            cmd = first_cmd(st_ff.ctrl, nsar, ndar);
            nxt_st.phase = first_phase(st_ff.ctrl);
          end
          else
          begin
            nxt_st.bus_req = 1'b0;
            nxt_st.phase = PH_IDLE;
          end
        end
      end
      default: nxt_st.phase = PH_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_ff <= '{phase: PH_IDLE, source_address_reg: ADDR_RST, sar_init: ADDR_RST, dest_address_reg: ADDR_RST,
                 ptr: ADDR_RST, cnt: CNT_RST, ctrl: CTRL_RST, oper: OPER_RST,
                 default: '0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

endmodule : drt_dma_top

/* File: hw/drt_mem_cycle.sv */
// Purpose: One memory bus cycle at a time for the DMA channel
// Assumes: Memory completes a cycle on a clock with wait low
// Notes: A new command may start in the cycle the previous one ends
`timescale 1ns/10ps
module drt_mem_cycle (
  input wire logic clk,
  input wire logic rst_n,
  input wire drt_pkg::drt_cmd_s cmd,
  input wire logic mem_wait,
  output drt_pkg::drt_mem_s mem,
  output logic done
);
  import drt_pkg::*;

  typedef struct packed {
    drt_mem_s bus;
    logic no_wait;
  } drt_cyc_s;

  drt_cyc_s st_ff;
  drt_cyc_s nxt_st;

  // Cycle ends on wait low, or at once when wait is to be ignored
  assign done = st_ff.bus.req & (~mem_wait | st_ff.no_wait);
  assign mem = st_ff.bus;

  // Retire finished cycle, load next command
  always_comb
  begin
    nxt_st = st_ff;
    if (done)
    begin
      nxt_st.bus.req = 1'b0;
    end
    if (cmd.start && (!st_ff.bus.req || done))
    begin
      nxt_st.bus.req = 1'b1;
      nxt_st.bus.we = cmd.we;
      nxt_st.bus.tack = cmd.tack;
      nxt_st.bus.size = cmd.size;
      nxt_st.bus.addr = cmd.addr;
      nxt_st.bus.wdata = cmd.wdata;
      nxt_st.no_wait = cmd.no_wait;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

endmodule : drt_mem_cycle
